// File: testbench/sbl_far_model.sv
// Far side of the block: crystal tick source and one peripheral status flag.
// Assumes the block's clock gates and clear grants are registered on mclk.
`timescale 1ns/1ps
module sbl_far_model
  import sbl_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire sbl_pkg::sbl_clk_en_type clk_en, // Clock gates from the block
  input wire logic grant, // Clear grant for this flag
  input wire logic flag_set, // Event that sets the flag
  output logic xtal_tick, // One pulse per crystal cycle
  output logic flag_q // Peripheral status flag
);
  // Crystal at half mclk, silent while its output is gated
  always_ff @(posedge mclk) begin
    if (!rst_n || !clk_en.xtal) begin
      xtal_tick <= 1'b0;
    end else begin
      xtal_tick <= !xtal_tick;
    end
  end
  // Flag clears only on a grant or on reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (grant) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// File: testbench/system_break_lowpower_reset_status_bench.sv
// Self-checking bench of the break, low-power and reset-cause block.
// Assumes the far model supplies crystal ticks; recovery counts are shortened.
`timescale 1ns/1ps
module system_break_lowpower_reset_status_bench;
  import sbl_pkg::*;
  localparam int unsigned RL = 64;
  localparam int unsigned RS = 8;
  logic mclk, rst_n, break_req, break_done, wait_exec, stop_exec, irq_req, flag_set;
  logic ack, xtal_tick, vec, imask, stack, wdog, brk, irq, flag_q;
  logic [3:0] clr, st1, st2, grant;
  logic [31:0] rdat, dat_o;
  sbl_wb_req_type req;
  sbl_cause_type cause;
  sbl_clk_en_type clk_en;
  int num_errors = 0;
  int checks = 0;

  sbl_sim_core #(.NF(4), .REC_LONG(RL), .REC_SHORT(RS)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .wb_req(req), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .break_req(break_req), .break_done(break_done), .wait_exec(wait_exec), .stop_exec(stop_exec),
    .irq_req(irq_req), .xtal_tick(xtal_tick), .rst_cause(cause), .flag_clr_req(clr),
    .flag_step1(st1), .flag_step2(st2), .flag_clr_grant(grant), .soft_vector_force(vec),
    .imask_clear(imask), .stack_start(stack), .clk_en(clk_en), .watchdog_en(wdog),
    .break_active(brk), .irq_o(irq));
  sbl_far_model far_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .grant(grant[0]),
    .flag_set(flag_set), .xtal_tick(xtal_tick), .flag_q(flag_q));

  task automatic summarize;
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // One classic cycle; entered just after a rising edge
  task automatic wb(input bit we, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    if (n >= 20) begin
      check(1'b0, "bus timeout");
      summarize();
    end
    req <= '0;
    @(posedge mclk);
  endtask

  task automatic do_reset(input sbl_cause_type c);
    rst_n <= 1'b0;
    cause <= c;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic sc_regs;
    wb(1, SBL_IDX_BREAK_FLAG_CTRL, 8'hff);
    wb(0, SBL_IDX_BREAK_FLAG_CTRL, 8'h00);
    check(rdat === 32'h80, "clear enable layout");
    wb(1, SBL_IDX_BREAK_FLAG_CTRL, 8'h00);
    wb(0, SBL_IDX_BREAK_FLAG_CTRL, 8'h00);
    check(rdat === 32'h0, "clear enable stuck");
    wb(1, 16'hfe02, 8'hff);
    wb(0, 16'hfe02, 8'h00);
    check(rdat === 32'h0, "unmapped read");
    wb(1, SBL_IDX_OPTION, 8'h01);
    @(posedge mclk);
    check(wdog === 1'b0, "watchdog not disabled");
    wb(1, SBL_IDX_OPTION, 8'h00);
    @(posedge mclk);
    check(wdog === 1'b1, "watchdog enable");
  endtask

  task automatic sc_break;
    wb(1, SBL_IDX_IRQ_MASK, 8'h01);
    flag_set <= 1'b1;
    st1 <= 4'h2;
    @(posedge mclk);
    flag_set <= 1'b0;
    st1 <= 4'h0;
    break_req <= 1'b1;
    @(posedge mclk);
    #1;
    check(vec === 1'b1 && brk === 1'b1, "break entry");
    @(posedge mclk);
    clr <= 4'h1;
    st2 <= 4'h2;
    @(posedge mclk);
    clr <= 4'h0;
    st2 <= 4'h0;
    #1;
    check(grant === 4'h0, "clear not blocked");
    check(irq === 1'b1, "break event interrupt");
    @(posedge mclk);
    wb(1, SBL_IDX_BREAK_FLAG_CTRL, 8'h80);
    clr <= 4'h1;
    @(posedge mclk);
    clr <= 4'h0;
    #1;
    check(grant === 4'h1, "enabled clear refused");
    @(posedge mclk);
    break_done <= 1'b1;
    break_req <= 1'b0;
    @(posedge mclk);
    break_done <= 1'b0;
    wb(1, SBL_IDX_BREAK_FLAG_CTRL, 8'h00);
    check(brk === 1'b0 && flag_q === 1'b0, "flag after break");
    st2 <= 4'h2;
    @(posedge mclk);
    st2 <= 4'h0;
    #1;
    check(grant === 4'h2, "second step after break");
    @(posedge mclk);
    wb(1, SBL_IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge mclk);
    check(irq === 1'b0, "interrupt not cleared");
  endtask

  task automatic sc_wait;
    wait_exec <= 1'b1;
    @(posedge mclk);
    wait_exec <= 1'b0;
    #1;
    check(imask === 1'b1 && clk_en === 4'b0111, "wait entry");
    check(wdog === 1'b1, "watchdog in wait");
    @(posedge mclk);
    irq_req <= 1'b1;
    @(posedge mclk);
    #1;
    check(clk_en.cpu === 1'b1, "wait wake");
    @(posedge mclk);
    irq_req <= 1'b0;
    #1;
    check(stack === 1'b1, "stacking after wake");
    @(posedge mclk);
    wait_exec <= 1'b1;
    @(posedge mclk);
    wait_exec <= 1'b0;
    break_req <= 1'b1;
    repeat (3) @(posedge mclk);
    break_req <= 1'b0;
    wb(0, SBL_IDX_BREAK_STATUS, 8'h00);
    check(rdat[1] === 1'b1 && clk_en.cpu === 1'b1, "break exit flag");
    break_done <= 1'b1;
    @(posedge mclk);
    break_done <= 1'b0;
    wb(1, SBL_IDX_BREAK_STATUS, 8'h00);
    wb(0, SBL_IDX_BREAK_STATUS, 8'h00);
    check(rdat[1] === 1'b0, "exit flag kept");
  endtask

  task automatic sc_stop(input bit short_sel, input int n_exp);
    int n;
    int k;
    wb(1, SBL_IDX_OPTION, {6'h0, short_sel, 1'b0});
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    #1;
    check(clk_en === 4'b0000 && imask === 1'b1, "stop entry");
    repeat (5) @(posedge mclk);
    irq_req <= 1'b1;
    n = 0;
    k = 0;
    while (n < n_exp && k < 5000) begin
      @(posedge mclk);
      k++;
      if (xtal_tick === 1'b1) n++;
      if (clk_en.cpu !== 1'b0 || stack !== 1'b0) check(1'b0, "early recovery");
    end
    k = 0;
    while (stack !== 1'b1 && k < 6) begin
      @(posedge mclk);
      k++;
    end
    check(stack === 1'b1 && n == n_exp, "stacking after recovery");
    if (stack !== 1'b1 || n != n_exp) begin
      summarize();
    end
    irq_req <= 1'b0;
    @(posedge mclk);
    check(clk_en === 4'b1111, "clocks after recovery");
  endtask

  task automatic sc_cause;
    for (int i = 0; i < 6; i++) begin
      do_reset(sbl_cause_type'(6'h20 >> i));
      wb(0, SBL_IDX_RESET_CAUSE, 8'h00);
      check(rdat[7:0] === (8'h80 >> i), "reset cause flag");
      wb(0, SBL_IDX_RESET_CAUSE, 8'h00);
      check(rdat[7:0] === 8'h00, "cause kept after read");
    end
    do_reset(6'h3f);
    wb(0, SBL_IDX_RESET_CAUSE, 8'h00);
    check(rdat[7:0] === 8'h80, "power-on cause");
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    cause = 6'h20;
    {break_req, break_done, wait_exec, stop_exec, irq_req, flag_set} = 6'h00;
    {clr, st1, st2} = 12'h000;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    sc_regs();
    sc_break();
    sc_wait();
    sc_stop(1'b1, RS);
    sc_stop(1'b0, RL);
    sc_cause();
    summarize();
  end
endmodule

// File: verilog/sbl_pkg.sv
// Constants, register map and carrier types of the break, low-power and reset-cause block.
// Assumes a byte-addressed classic Wishbone slave port with 32-bit data.
package sbl_pkg;
  localparam int unsigned SBL_ADR_W = 18;
  localparam int unsigned SBL_IDX_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [15:0] SBL_IDX_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] SBL_IDX_RESET_CAUSE = 16'hfe01;
  localparam logic [15:0] SBL_IDX_BREAK_FLAG_CTRL = 16'hfe03;
  localparam logic [15:0] SBL_IDX_IRQ_STATUS = 16'hfe04;
  localparam logic [15:0] SBL_IDX_IRQ_MASK = 16'hfe05;
  localparam logic [15:0] SBL_IDX_OPTION = 16'hfe06;
  // Field positions
  localparam int unsigned SBL_EXIT_FLAG_BIT = 1;
  localparam int unsigned SBL_CLR_EN_BIT = 7;
  localparam int unsigned SBL_OPT_WDOG_DIS_BIT = 0;
  localparam int unsigned SBL_OPT_SHORT_REC_BIT = 1;
  localparam int unsigned SBL_IRQ_W = 2;
  localparam int unsigned SBL_IRQ_BREAK_BIT = 0;
  localparam int unsigned SBL_IRQ_WAKE_BIT = 1;
  // Reset values
  localparam logic [7:0] SBL_OPTION_RST = 8'h00;
  localparam logic [SBL_IRQ_W-1:0] SBL_IRQ_MASK_RST = 2'h0;
  // STOP recovery, in crystal clock cycles
  localparam int unsigned SBL_REC_W = 13;
  localparam int unsigned SBL_REC_LONG = 4096;
  localparam int unsigned SBL_REC_SHORT = 32;

  typedef enum logic [1:0] {SBL_RUN, SBL_WAIT, SBL_STOP, SBL_RECOVER} sbl_lp_state_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [SBL_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sbl_wb_req_type;

  // Bit order matches the reset cause register, bit 7 down to bit 2
  typedef struct packed {
    logic por;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
    logic undervoltage;
  } sbl_cause_type;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic base;
    logic xtal;
  } sbl_clk_en_type;
endpackage

// File: verilog/sbl_sim_core.sv
// Break entry, flag-clear protection, WAIT/STOP sequencing and reset-cause latch.
// Assumes one clock; crystal edges arrive as a one-cycle xtal_tick pulse on mclk.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

// How it works
// - Break request enters break state and forces a software interrupt vector fetch.
// - In break, flag clears are blocked unless the clear enable bit is set.
// - A flag cleared in break with clearing enabled stays cleared afterwards.
// - Two-step clears stay protected in break; second step after break clears.
// - STOP or WAIT clears the interrupt mask and unclocks the CPU on the same edge.
// - WAIT stops CPU clocks, peripheral clocks keep running.
// - Enabled interrupt wakes WAIT; stacking starts one cycle later.
// - Reset or break also ends WAIT/STOP; break sets the exit flag.
// - Watchdog enabled and running in WAIT when its disable option is zero.
// - STOP resets the counter and stops base and crystal clock outputs.
// - Interrupt, reset or break ends STOP; stacking waits for recovery.
// - Recovery is 4096 crystal cycles, or 32 with short recovery selected.
// - Counter held reset from STOP until recovery, then times recovery.
// - Break status, reset cause and break flag control registers are mapped.
// - Exit flag clears on writing zero or on reset; readable in break.
// - Reading reset cause clears it; power-on sets only its own flag.
// - Reset cause holds one flag per reset source.
// - Clear enable is read/write bit 7; other bits reserved.
module sbl_sim_core
  import sbl_pkg::*;
#(
  parameter int unsigned NF = 4,
  parameter int unsigned REC_LONG = SBL_REC_LONG,
  parameter int unsigned REC_SHORT = SBL_REC_SHORT
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire sbl_pkg::sbl_wb_req_type wb_req, // Wishbone request
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic break_req, // Break module request
  input wire logic break_done, // Break service finished
  input wire logic wait_exec, // WAIT instruction executed
  input wire logic stop_exec, // STOP instruction executed
  input wire logic irq_req, // Enabled module interrupt
  input wire logic xtal_tick, // One crystal clock cycle
  input wire sbl_pkg::sbl_cause_type rst_cause, // Source of the last reset
  input wire logic [NF-1:0] flag_clr_req, // One-step flag clear attempt
  input wire logic [NF-1:0] flag_step1, // First step of two-step clear
  input wire logic [NF-1:0] flag_step2, // Second step of two-step clear
  output logic [NF-1:0] flag_clr_grant, // Peripheral may clear flag
  output logic soft_vector_force, // Force software interrupt vector fetch
  output logic imask_clear, // Clear CPU interrupt mask
  output logic stack_start, // Begin interrupt stacking
  output sbl_pkg::sbl_clk_en_type clk_en, // Clock gates
  output logic watchdog_en, // Watchdog enable
  output logic break_active, // Break state
  output logic irq_o // Block interrupt
);
  import sbl_pkg::*;

  logic ack_reg;
  logic [31:0] rd_dat_reg;
  logic [SBL_IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic break_state_reg;
  logic soft_vector_reg;
  logic brk_entry;
  logic clr_en_reg;
  logic [7:0] option_reg;
  logic clr_allow;
  logic [NF-1:0] arm_reg;
  logic [NF-1:0] grant_reg;
  logic [NF-1:0] grant_next;
  sbl_lp_state_type lp_reg;
  sbl_lp_state_type lp_next;
  logic imask_clear_reg;
  logic wake_irq_reg;
  logic rec_irq_reg;
  logic stack_start_reg;
  logic [SBL_REC_W-1:0] rec_cnt_reg;
  logic [SBL_REC_W-1:0] rec_last;
  logic rec_done;
  sbl_clk_en_type clk_en_reg;
  logic watchdog_en_reg;
  logic exit_flag_reg;
  logic exit_flag_set;
  logic first_reg;
  sbl_cause_type cause_reg;
  logic [SBL_IRQ_W-1:0] irq_stat_reg;
  logic [SBL_IRQ_W-1:0] irq_mask_reg;
  logic [SBL_IRQ_W-1:0] irq_event;
  logic irq_o_reg;
  logic lp_low;
  logic acc;

  // Wishbone decode; one wait state, ack high for one cycle
  // Writes and read side effects land on the edge that sees ack high
  assign idx = wb_req.adr[SBL_ADR_W-1:2];
  assign req = wb_req.cyc & wb_req.stb & ~ack_reg;
  assign acc = wb_req.cyc & wb_req.stb & ack_reg;
  assign wr = acc & wb_req.we & wb_req.sel[0];
  assign rd = req & ~wb_req.we;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_dat_reg <= 32'h0;
    end else if (rd) begin
      case (idx)
        SBL_IDX_BREAK_STATUS: rd_dat_reg <= {30'h0, exit_flag_reg, 1'b0};
        SBL_IDX_RESET_CAUSE: rd_dat_reg <= {24'h0, cause_reg, 2'h0};
        SBL_IDX_BREAK_FLAG_CTRL: rd_dat_reg <= {24'h0, clr_en_reg, 7'h0};
        SBL_IDX_IRQ_STATUS: rd_dat_reg <= {30'h0, irq_stat_reg};
        SBL_IDX_IRQ_MASK: rd_dat_reg <= {30'h0, irq_mask_reg};
        SBL_IDX_OPTION: rd_dat_reg <= {24'h0, option_reg};
        default: rd_dat_reg <= 32'h0;
      endcase
    end
  end

  // Break state
  assign brk_entry = break_req & ~break_state_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      break_state_reg <= 1'b0;
      soft_vector_reg <= 1'b0;
    end else begin
      soft_vector_reg <= brk_entry;
      if (brk_entry) begin
        break_state_reg <= 1'b1;
      end else if (break_done) begin
        break_state_reg <= 1'b0;
      end
    end
  end

  // Software-written control
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clr_en_reg <= 1'b0;
      option_reg <= SBL_OPTION_RST;
      irq_mask_reg <= SBL_IRQ_MASK_RST;
    end else if (wr) begin
      if (idx == SBL_IDX_BREAK_FLAG_CTRL) begin
        clr_en_reg <= wb_req.dat[SBL_CLR_EN_BIT];
      end
      if (idx == SBL_IDX_OPTION) begin
        option_reg <= wb_req.dat[7:0];
      end
      if (idx == SBL_IDX_IRQ_MASK) begin
        irq_mask_reg <= wb_req.dat[SBL_IRQ_W-1:0];
      end
    end
  end

  // Flag clear protection; a grant is final, so a cleared flag stays cleared
  assign clr_allow = ~break_state_reg | clr_en_reg;
  assign grant_next = {NF{clr_allow}} & (flag_clr_req | (flag_step2 & arm_reg));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arm_reg <= '0;
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
      // First step survives a blocked second step
      arm_reg <= (arm_reg & ~(flag_step2 & grant_next)) | flag_step1;
    end
  end

  // Low-power sequencing
  assign rec_last = option_reg[SBL_OPT_SHORT_REC_BIT] ? SBL_REC_W'(REC_SHORT - 1)
                                                      : SBL_REC_W'(REC_LONG - 1);
  assign rec_done = (lp_reg == SBL_RECOVER) & xtal_tick & (rec_cnt_reg == rec_last);
  assign lp_low = (lp_reg == SBL_WAIT) | (lp_reg == SBL_STOP);

  always_comb begin
    lp_next = lp_reg;
    case (lp_reg)
      SBL_RUN: begin
        if (stop_exec) begin
          lp_next = SBL_STOP;
        end else if (wait_exec) begin
          lp_next = SBL_WAIT;
        end
      end
      SBL_WAIT: begin
        if (irq_req | break_req) begin
          lp_next = SBL_RUN;
        end
      end
      SBL_STOP: begin
        if (irq_req | break_req) begin
          lp_next = SBL_RECOVER;
        end
      end
      SBL_RECOVER: begin
        if (rec_done) begin
          lp_next = SBL_RUN;
        end
      end
      default: lp_next = SBL_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lp_reg <= SBL_RUN;
      clk_en_reg <= '1;
    end else begin
      lp_reg <= lp_next;
      clk_en_reg.cpu <= (lp_next == SBL_RUN);
      clk_en_reg.periph <= (lp_next == SBL_RUN) | (lp_next == SBL_WAIT);
      clk_en_reg.base <= (lp_next == SBL_RUN) | (lp_next == SBL_WAIT);
      clk_en_reg.xtal <= (lp_next != SBL_STOP);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rec_cnt_reg <= '0;
    end else if (lp_reg != SBL_RECOVER) begin
      rec_cnt_reg <= '0;
    end else if (xtal_tick) begin
      rec_cnt_reg <= rec_cnt_reg + SBL_REC_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      imask_clear_reg <= 1'b0;
      wake_irq_reg <= 1'b0;
      rec_irq_reg <= 1'b0;
      stack_start_reg <= 1'b0;
    end else begin
      imask_clear_reg <= (lp_reg == SBL_RUN) & (wait_exec | stop_exec);
      wake_irq_reg <= (lp_reg == SBL_WAIT) & irq_req;
      if (lp_reg == SBL_STOP) begin
        rec_irq_reg <= irq_req;
      end
      stack_start_reg <= wake_irq_reg | (rec_done & rec_irq_reg);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      watchdog_en_reg <= 1'b0;
    end else begin
      watchdog_en_reg <= ~option_reg[SBL_OPT_WDOG_DIS_BIT];
    end
  end

  // Stop-wait break exit flag; set wins over a software clear
  assign exit_flag_set = lp_low & break_req;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      exit_flag_reg <= 1'b0;
    end else if (exit_flag_set) begin
      exit_flag_reg <= 1'b1;
    end else if (wr && idx == SBL_IDX_BREAK_STATUS && !wb_req.dat[SBL_EXIT_FLAG_BIT]) begin
      exit_flag_reg <= 1'b0;
    end
  end

  // Reset cause caught on the first edge after release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      first_reg <= 1'b1;
      cause_reg <= '0;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        if (rst_cause.por) begin
          cause_reg <= '{por: 1'b1, default: 1'b0};
        end else begin
          cause_reg <= rst_cause;
        end
      end else if (acc && !wb_req.we && idx == SBL_IDX_RESET_CAUSE) begin
        cause_reg <= '0;
      end
    end
  end

  // Event status, write one to clear, set wins
  assign irq_event = {lp_low & (lp_next != lp_reg), brk_entry};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_o_reg <= 1'b0;
    end else begin
      if (wr && idx == SBL_IDX_IRQ_STATUS) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_req.dat[SBL_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_event;
      end
      irq_o_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign wb_dat_o = rd_dat_reg;
  assign wb_ack_o = ack_reg;
  assign flag_clr_grant = grant_reg;
  assign soft_vector_force = soft_vector_reg;
  assign imask_clear = imask_clear_reg;
  assign stack_start = stack_start_reg;
  assign clk_en = clk_en_reg;
  assign watchdog_en = watchdog_en_reg;
  assign break_active = break_state_reg;
  assign irq_o = irq_o_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_break_entry_vector: assert property (brk_entry |=> soft_vector_reg && break_state_reg)
    else $error("break entry did not force the software interrupt");
  chk_vector_one_cycle: assert property (soft_vector_reg |=> !soft_vector_reg)
    else $error("vector force longer than one cycle");
  chk_break_held: assert property (break_state_reg && !break_done |=> break_state_reg)
    else $error("break state left without break done");
  chk_clear_blocked: assert property (break_state_reg && !clr_en_reg |=> grant_reg == '0)
    else $error("flag clear granted while protected");
  chk_clear_enabled: assert property (clr_allow && flag_clr_req[0] |=> grant_reg[0])
    else $error("enabled flag clear not granted");
  chk_two_step_held: assert property (flag_step1[1] ##1 (!flag_step2[1] && !grant_next[1]) |-> arm_reg[1])
    else $error("first clear step lost");
  chk_step_after_break: assert property (!break_state_reg && arm_reg[1] && flag_step2[1] |=> grant_reg[1])
    else $error("second clear step after break not granted");
  chk_entry_mask_clear: assert property ((lp_reg == SBL_RUN) && (wait_exec || stop_exec)
    |=> imask_clear_reg && !clk_en_reg.cpu)
    else $error("low-power entry did not clear mask and stop cpu clock");
  chk_wait_entry: assert property (lp_reg == SBL_RUN && wait_exec && !stop_exec |=> lp_reg == SBL_WAIT)
    else $error("wait instruction did not enter wait");
  chk_wait_clocks: assert property (lp_reg == SBL_WAIT |-> !clk_en_reg.cpu && clk_en_reg.periph)
    else $error("wrong clock gating in wait");
  chk_wait_wake_stack: assert property ((lp_reg == SBL_WAIT) && irq_req |=> ##1 stack_start_reg)
    else $error("stacking not started one cycle after wait wake");
  chk_break_exit_flag: assert property (lp_low && break_req |=> exit_flag_reg && (lp_reg != SBL_WAIT))
    else $error("break exit flag not set");
  chk_stop_wake: assert property (lp_reg == SBL_STOP && (irq_req || break_req)
    |=> lp_reg == SBL_RECOVER)
    else $error("stop not left on interrupt or break");
  chk_watchdog_follow: assert property ($past(rst_n)
    |-> watchdog_en_reg == !$past(option_reg[SBL_OPT_WDOG_DIS_BIT]))
    else $error("watchdog enable does not follow option");
  chk_stop_clocks: assert property (lp_reg == SBL_STOP
    |-> !clk_en_reg.base && !clk_en_reg.xtal && rec_cnt_reg == '0)
    else $error("stop mode clocks or counter wrong");
  chk_recover_xtal: assert property (lp_reg == SBL_RECOVER |-> clk_en_reg.xtal && !clk_en_reg.cpu)
    else $error("recovery clock gating wrong");
  chk_recover_hold: assert property (lp_reg == SBL_RECOVER && !xtal_tick |=> $stable(rec_cnt_reg))
    else $error("recovery counter moved without a crystal tick");
  chk_recover_end: assert property ((lp_reg == SBL_RECOVER) && xtal_tick && rec_cnt_reg == rec_last
    |=> lp_reg == SBL_RUN)
    else $error("recovery did not end at its count");
  chk_exit_flag_clear: assert property (wr && idx == SBL_IDX_BREAK_STATUS && !wb_req.dat[SBL_EXIT_FLAG_BIT]
    && !exit_flag_set |=> !exit_flag_reg)
    else $error("break exit flag not cleared by write of zero");
  chk_cause_read_clear: assert property (acc && !wb_req.we && idx == SBL_IDX_RESET_CAUSE && !first_reg
    |=> cause_reg == '0)
    else $error("reset cause not cleared by read");
  chk_cause_por_only: assert property (rst_n && first_reg && rst_cause.por
    |=> cause_reg == sbl_cause_type'(6'h20))
    else $error("power-on cause not alone");
  chk_irq_level: assert property ($past(rst_n)
    |-> irq_o_reg == |($past(irq_stat_reg) & $past(irq_mask_reg)))
    else $error("interrupt output does not follow status and mask");
endmodule
